/* inc/pwc_cfg.svh */
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

// Register byte offsets on the APB bus.
`define PWC_OFF_SC     12'h000
`define PWC_OFF_COUNT  12'h004
`define PWC_OFF_LIMIT  12'h008
`define PWC_OFF_EVT    12'h00C
`define PWC_OFF_MASK   12'h010

// Field positions inside the status/control byte.
`define PWC_SC_FLAG    7
`define PWC_SC_CLKS_HI 6
`define PWC_SC_CLKS_LO 5
`define PWC_SC_IE      4
`define PWC_SC_PS_HI   3
`define PWC_SC_PS_LO   0

// Event bit positions in the event status and mask registers.
`define PWC_EVT_MATCH  0
`define PWC_EVT_RESTART 1

// Reset values.
`define PWC_RST_BYTE   8'h00
`define PWC_RST_EVT    2'h0
`define PWC_RST_PRE    18'h00000

// Clock source codes.
`define PWC_SRC_LPO    2'h0
`define PWC_SRC_EXT    2'h1

`endif

/* inc/pwc_pkg.sv */
package pwc_pkg;

    // Status/control byte in its printed bit order.
    typedef struct packed {
        logic       match_flag;
        logic [1:0] clock_source_select;
        logic       match_irq_enable;
        logic [3:0] prescale_select;
    } pwc_sc_t;

    // Sticky events seen by the interrupt path.
    typedef struct packed {
        logic restart;
        logic match;
    } pwc_evt_t;

    // Settings handed to the prescaler.
    typedef struct packed {
        logic       decimal_bank;
        logic [3:0] prescale_select;
    } pwc_pre_cfg_t;

endpackage

/* verilog/pwc_prescaler.sv */
`timescale 1ns/1ps
`include "pwc_cfg.svh"

module pwc_prescaler
    import pwc_pkg::*;
#(
    parameter int PRE_W = 18
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         src_edge,
    input  wire logic         clear,
    input  wire logic         hold,
    input  wire pwc_pre_cfg_t cfg,
    output logic              tick
);

    logic [PRE_W-1:0] cnt;
    logic [PRE_W-1:0] divisor;
    logic             off;
    logic             last;

    ////////////////////////////////////////////////////////////////////////////
    // Divisor table; a zero divisor means the prescaler is off.
    function automatic logic [PRE_W-1:0] div_of(input pwc_pre_cfg_t c);
        logic [17:0] d;
        d = 18'h00000;
        case ({c.decimal_bank, c.prescale_select})
            5'h01: d = 18'h00008;
            5'h02: d = 18'h00020;
            5'h03: d = 18'h00040;
            5'h04: d = 18'h00080;
            5'h05: d = 18'h00100;
            5'h06: d = 18'h00200;
            5'h07: d = 18'h00400;
            5'h08: d = 18'h00001;
            5'h09: d = 18'h00002;
            5'h0A: d = 18'h00004;
            5'h0B: d = 18'h0000A;
            5'h0C: d = 18'h00010;
            5'h0D: d = 18'h00064;
            5'h0E: d = 18'h001F4;
            5'h0F: d = 18'h003E8;
            5'h11: d = 18'h00400;
            5'h12: d = 18'h00800;
            5'h13: d = 18'h01000;
            5'h14: d = 18'h02000;
            5'h15: d = 18'h04000;
            5'h16: d = 18'h08000;
            5'h17: d = 18'h10000;
            5'h18: d = 18'h003E8;
            5'h19: d = 18'h007D0;
            5'h1A: d = 18'h01388;
            5'h1B: d = 18'h02710;
            5'h1C: d = 18'h04E20;
            5'h1D: d = 18'h0C350;
            5'h1E: d = 18'h186A0;
            5'h1F: d = 18'h30D40;
            default: d = 18'h00000;
        endcase
        return PRE_W'(d);
    endfunction

    assign divisor = div_of(cfg);
    assign off     = (divisor == '0);
    assign last    = (cnt == divisor - PRE_W'(1));

    // Counts source edges; holding keeps the partial period for resume.
    always_ff @(posedge clk) begin
        if (srst || clear || off) begin
            cnt  <= `PWC_RST_PRE;
            tick <= 1'b0;
        end else if (src_edge && !hold) begin
            cnt  <= last ? '0 : cnt + PRE_W'(1);
            tick <= last;
        end else begin
            tick <= 1'b0;
        end
    end

endmodule // pwc_prescaler

/* verilog/pwc_periodic_wakeup_counter.sv */
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "pwc_cfg.svh"

module pwc_periodic_wakeup_counter
    import pwc_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 8,
    parameter int PRE_W  = 18
) (
    input  wire logic              SYS_CLK,
    input  wire logic              SRST,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              LOW_POWER_OSC_CLOCK,
    input  wire logic              EXTERNAL_REF_CLOCK,
    input  wire logic              INTERNAL_REF_CLOCK,
    input  wire logic              DEBUG_HALT,
    output logic                   IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    pwc_sc_t          sc;
    logic [CNT_W-1:0] count_value;
    logic [CNT_W-1:0] match_limit;
    pwc_evt_t         evt_status;
    pwc_evt_t         evt_mask;

    logic [2:0]       src_meta;
    logic [2:0]       src_sync;
    logic [2:0]       src_prev;
    logic [2:0]       src_rise;
    logic             sel_edge;

    logic             pre_tick;
    logic             pre_clear;
    pwc_pre_cfg_t     pre_cfg;
    logic             step;
    logic             at_limit;
    logic             match_event;

    logic             access;
    logic             done;
    logic             wr_done;
    logic             rd_done;
    logic             hit_sc;
    logic             hit_count;
    logic             hit_limit;
    logic             hit_evt;
    logic             hit_mask;
    logic             mapped;
    logic [31:0]      rd_mux;

    pwc_sc_t          wr_sc;
    logic             wr_sc_en;
    logic             src_changed;
    logic             ps_changed;
    logic             flag_clear;
    logic             evt_clear;
    logic             next_flag;
    pwc_evt_t         next_evt;
    logic             next_irq;

    ////////////////////////////////////////////////////////////////////////////
    // Clock source synchronisers.

    // Each source pin is foreign to SYS_CLK, so it passes two flops first.
    // The sources must be well below half of SYS_CLK to be counted.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_src
            always_ff @(posedge SYS_CLK) begin
                if (SRST) begin
                    src_meta[gi] <= 1'b0;
                    src_sync[gi] <= 1'b0;
                    src_prev[gi] <= 1'b0;
                end else begin
                    src_meta[gi] <= (gi == 0) ? LOW_POWER_OSC_CLOCK :
                                    (gi == 1) ? EXTERNAL_REF_CLOCK :
                                                INTERNAL_REF_CLOCK;
                    src_sync[gi] <= src_meta[gi];
                    src_prev[gi] <= src_sync[gi];
                end
            end
            assign src_rise[gi] = src_sync[gi] & ~src_prev[gi];
        end
    endgenerate

    // Source selection; both codes with the high bit set pick the internal clock.
    assign sel_edge = (sc.clock_source_select == `PWC_SRC_LPO) ? src_rise[0] :
                      (sc.clock_source_select == `PWC_SRC_EXT) ? src_rise[1] :
                                                                 src_rise[2];

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.

    // Every access takes one wait state so that PREADY can come from a flop.
    assign access    = PSEL & PENABLE;
    assign done      = access & PREADY;
    assign wr_done   = done & PWRITE;
    assign rd_done   = done & ~PWRITE;

    assign hit_sc    = (PADDR == `PWC_OFF_SC);
    assign hit_count = (PADDR == `PWC_OFF_COUNT);
    assign hit_limit = (PADDR == `PWC_OFF_LIMIT);
    assign hit_evt   = (PADDR == `PWC_OFF_EVT);
    assign hit_mask  = (PADDR == `PWC_OFF_MASK);
    assign mapped    = hit_sc | hit_count | hit_limit | hit_evt | hit_mask;

    // Read data; narrower registers sit in the low bits, the rest reads zero.
    assign rd_mux = hit_sc    ? {24'h000000, sc}                  :
                    hit_count ? {24'h000000, count_value}         :
                    hit_limit ? {24'h000000, match_limit}         :
                    hit_evt   ? {30'h0, evt_status}               :
                    hit_mask  ? {30'h0, evt_mask}                 :
                                32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Write side effects.

    assign wr_sc       = pwc_sc_t'(PWDATA[7:0]);
    assign wr_sc_en    = wr_done & hit_sc;

    // Only a value that differs restarts the time base; a rewrite is harmless.
    assign src_changed = wr_sc_en &
                         (wr_sc.clock_source_select != sc.clock_source_select);
    assign ps_changed  = wr_sc_en &
                         (wr_sc.prescale_select != sc.prescale_select);

    // Any limit write, or a changed source or prescale, restarts from zero.
    assign pre_clear   = src_changed | ps_changed | (wr_done & hit_limit);

    // Writing 1 to the flag clears it; writing 0 leaves it alone.
    assign flag_clear  = wr_sc_en & wr_sc.match_flag;
    assign evt_clear   = rd_done & hit_evt;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler.

    // Low bit of the source field chooses the first or the second divisor bank.
    assign pre_cfg.decimal_bank    = sc.clock_source_select[0];
    assign pre_cfg.prescale_select = sc.prescale_select;

    pwc_prescaler #(
        .PRE_W    (PRE_W)
    ) u_prescaler (
        .clk      (SYS_CLK),
        .srst     (SRST),
        .src_edge (sel_edge),
        .clear    (pre_clear),
        .hold     (DEBUG_HALT),
        .cfg      (pre_cfg),
        .tick     (pre_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Main counter.

    // A tick already in flight when debug halt rises is dropped as well.
    assign step        = pre_tick & ~DEBUG_HALT;
    assign at_limit    = (count_value == match_limit);
    assign match_event = step & at_limit;

    // Counts up once per prescaler period and wraps to zero after the limit.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            count_value <= CNT_W'(`PWC_RST_BYTE);
        end else if (pre_clear) begin
            count_value <= '0;
        end else if (match_event) begin
            count_value <= '0;
        end else if (step) begin
            count_value <= count_value + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag and interrupt next state.

    // A match in the clearing cycle wins, so no period is ever lost.
    assign next_flag = match_event ? 1'b1 :
                       flag_clear  ? 1'b0 :
                                     sc.match_flag;

    // Event bits are sticky; a flag-clear write also drops the match request.
    assign next_evt.match   = match_event |
                              (evt_status.match & ~evt_clear & ~flag_clear);
    assign next_evt.restart = pre_clear |
                              (evt_status.restart & ~evt_clear);

    // Request while the enabled flag is up, or while an unmasked event stands.
    assign next_irq = (next_flag & sc.match_irq_enable &
                       ~(wr_sc_en & ~wr_sc.match_irq_enable)) |
                      (|(next_evt & evt_mask & ~({2{wr_done & hit_mask}}))) |
                      (|(next_evt & pwc_evt_t'(PWDATA[1:0]) &
                         {2{wr_done & hit_mask}}));

    ////////////////////////////////////////////////////////////////////////////
    // Control and status registers.

    // Status/control: the flag follows its own rule, the rest is plain storage.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sc <= pwc_sc_t'(`PWC_RST_BYTE);
        end else begin
            sc.match_flag <= next_flag;
            if (wr_sc_en) begin
                sc.clock_source_select <= wr_sc.clock_source_select;
                sc.match_irq_enable    <= wr_sc.match_irq_enable;
                sc.prescale_select     <= wr_sc.prescale_select;
            end
        end
    end

    // Limit register; the count register has no write path at all.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            match_limit <= CNT_W'(`PWC_RST_BYTE);
        end else if (wr_done && hit_limit) begin
            match_limit <= PWDATA[CNT_W-1:0];
        end
    end

    // Event status and mask.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            evt_status <= pwc_evt_t'(`PWC_RST_EVT);
            evt_mask   <= pwc_evt_t'(`PWC_RST_EVT);
        end else begin
            evt_status <= next_evt;
            if (wr_done && hit_mask) begin
                evt_mask <= pwc_evt_t'(PWDATA[1:0]);
            end
        end
    end

    // Interrupt output straight from a flop.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer.

    // Ready rises one cycle into the access phase and falls after it is taken.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= access & ~PREADY;
            PSLVERR <= access & ~PREADY & ~mapped;
            if (access && !PREADY && !PWRITE) begin
                PRDATA <= rd_mux;
            end
        end
    end

endmodule // pwc_periodic_wakeup_counter

/* sim/pwc_chk.sv */
`timescale 1ns/1ps
`include "pwc_cfg.svh"

module pwc_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              SYS_CLK,
    input wire logic              SRST,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire logic              DEBUG_HALT,
    input wire logic              IRQ
);
    logic [7:0] lim_shadow;
    logic [6:0] sc_shadow;
    logic [3:0] halt_age;
    logic       held_ok;
    logic [7:0] held_cnt;

    // Access decode; mapped covers every register the block answers for.
    wire wr_done = PREADY && PWRITE;
    wire rd_done = PREADY && !PWRITE;
    wire at_sc   = PADDR == `PWC_OFF_SC;
    wire at_cnt  = PADDR == `PWC_OFF_COUNT;
    wire at_lim  = PADDR == `PWC_OFF_LIMIT;
    wire mapped  = at_sc || at_cnt || at_lim || PADDR == `PWC_OFF_EVT || PADDR == `PWC_OFF_MASK;
    wire [3:0] next_halt_age = !DEBUG_HALT ? 4'h0 : (&halt_age ? halt_age : halt_age + 4'h1);

    // Shadows; a count is trusted only after a long halt, since a tick may still be in flight.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            lim_shadow <= 8'h00;
            sc_shadow  <= 7'h00;
            halt_age   <= 4'h0;
            held_ok    <= 1'b0;
            held_cnt   <= 8'h00;
        end else begin
            halt_age <= next_halt_age;
            if (wr_done && at_lim) lim_shadow <= PWDATA[7:0];
            if (wr_done && at_sc) sc_shadow <= PWDATA[6:0];
            if (!DEBUG_HALT || wr_done) held_ok <= 1'b0;
            else if (rd_done && at_cnt && halt_age > 4'h7 && !held_ok) begin
                held_ok  <= 1'b1;
                held_cnt <= PRDATA[7:0];
            end
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);

    sequence s_access_start;
        PSEL && $rose(PENABLE);
    endsequence
    sequence s_one_wait;
        !PREADY ##1 PREADY;
    endsequence

    ////////////////////////////////////////
    AST_ONE_WAIT: assert property (s_access_start |-> s_one_wait)
        else $error("ready did not follow exactly one wait cycle");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready stood longer than one cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("error flag without ready");
    AST_UNMAPPED: assert property (PREADY && !mapped |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (PREADY && mapped |-> !PSLVERR)
        else $error("mapped access refused");
    AST_UPPER_ZERO: assert property (rd_done |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_PRDATA_HOLD: assert property (!$past(SRST) && !rd_done |-> $stable(PRDATA))
        else $error("read data moved outside a read");
    AST_RESET_OUT: assert property (disable iff (1'b0) SRST |=> PRDATA == 32'h0 && !PREADY && !PSLVERR && !IRQ)
        else $error("outputs not cleared by reset");
    AST_LIMIT_RW: assert property (rd_done && at_lim |-> PRDATA[7:0] == lim_shadow)
        else $error("limit readback wrong");
    AST_SC_FIELDS: assert property (rd_done && at_sc |-> PRDATA[6:0] == sc_shadow)
        else $error("control fields readback wrong");
    AST_HALT_HELD: assert property (rd_done && at_cnt && held_ok |-> PRDATA[7:0] == held_cnt)
        else $error("count moved while halted");
endmodule // pwc_chk

/* sim/pwc_periodic_wakeup_counter_tb.sv */
`timescale 1ns/1ps
`include "pwc_cfg.svh"
`define PWC_EQ(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t: got %0h want %0h", $time, a, b); end end

module pwc_periodic_wakeup_counter_tb
    import pwc_pkg::*;
;
    localparam int DIV0[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
    localparam int DIV1[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000, 2000, 5000, 10000,
                                20000, 50000, 100000, 200000};
    logic        SYS_CLK, SRST, PSEL, PENABLE, PWRITE, DEBUG_HALT, PREADY, PSLVERR, IRQ, e;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, r;
    logic [2:0]  src;
    int          n_mismatch, tests_run, d, s, sp;
    pwc_sc_t     scv;

    // Free-running system clock.
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end

    pwc_periodic_wakeup_counter u_dut (
        .SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LOW_POWER_OSC_CLOCK(src[0]),
        .EXTERNAL_REF_CLOCK(src[1]), .INTERNAL_REF_CLOCK(src[2]), .DEBUG_HALT(DEBUG_HALT), .IRQ(IRQ));

    ////////////////////////////////////////
    // One APB transfer; waits for ready rather than assuming the one wait cycle.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        // Ready ends this wait, or the watchdog if it never comes; the latency is checked, not assumed.
        do begin
            @(posedge SYS_CLK);
            k++;
        end while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        `PWC_EQ(k, 2)
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0);
        `PWC_EQ(r, {24'h0, x})
        `PWC_EQ(e, 1'b0)
    endtask

    // Expected prescaler divisor for a status/control value, taken from the divisor tables.
    function automatic int exp_div(input pwc_sc_t c);
        return c.clock_source_select[0] ? DIV1[c.prescale_select] : DIV0[c.prescale_select];
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask

    // Source pulses stay two cycles per phase so the synchronisers never miss one; the pin
    // pulsed may be the selected source or an idle one.
    task automatic pulse(input int p, input int n);
        repeat (n) begin
            src[p] <= 1'b1;
            repeat (2) @(posedge SYS_CLK);
            src[p] <= 1'b0;
            repeat (2) @(posedge SYS_CLK);
        end
        repeat (8) @(posedge SYS_CLK);
    endtask

    task automatic irq_is(input logic x);
        repeat (3) @(posedge SYS_CLK);
        `PWC_EQ(IRQ, x)
    endtask

    task automatic do_reset(input int n);
        SRST <= 1'b1;
        repeat (n) @(posedge SYS_CLK);
        SRST <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    task automatic chk_rst();
        for (int i = 0; i < 5; i++) rd(12'(4 * i), 8'h00);
        `PWC_EQ(IRQ, 1'b0)
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog sized well above the longest divisor sweep.
    initial begin
        repeat (70000) @(posedge SYS_CLK);
        n_mismatch++;
        complete_run();
    end

    ////////////////////////////////////////
    initial begin
        {SRST, PSEL, PENABLE, PWRITE, DEBUG_HALT} = 5'h10;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        src = 3'h0;
        n_mismatch = 0;
        tests_run = 0;
        void'($urandom(41694));
        do_reset(12);
        chk_rst();
        wr(`PWC_OFF_LIMIT, 32'hFF);
        // Every divisor of the first bank, then the other sources; stray pulses hit idle pins.
        for (int i = 0; i < 19; i++) begin
            s = (i < 16) ? 0 : i - 15;
            sp = (s > 1) ? 2 : s;
            scv = {1'b0, s[1:0], 1'b0, (i < 16) ? i[3:0] : 4'h1};
            wr(`PWC_OFF_SC, {24'h0, scv});
            d = exp_div(scv);
            pulse((sp + 1 + $urandom_range(1, 0)) % 3, $urandom_range(3, 1));
            pulse(sp, (d == 0) ? 5 : d - 1);
            rd(`PWC_OFF_COUNT, 8'h00);
            if (d > 0) begin
                pulse(sp, 1);
                rd(`PWC_OFF_COUNT, 8'h01);
            end
        end
        // One decimal code of the second bank; the larger divisors would take too long.
        scv = 8'h28;
        wr(`PWC_OFF_SC, {24'h0, scv});
        d = exp_div(scv);
        pulse(1, d - 1);
        rd(`PWC_OFF_COUNT, 8'h00);
        pulse(1, 1);
        rd(`PWC_OFF_COUNT, 8'h01);
        wr(`PWC_OFF_SC, 32'h08);
        wr(`PWC_OFF_LIMIT, 32'h02);
        pulse(0, 2);
        rd(`PWC_OFF_COUNT, 8'h02);
        rd(`PWC_OFF_SC, 8'h08);
        pulse(0, 1);
        rd(`PWC_OFF_COUNT, 8'h00);
        rd(`PWC_OFF_SC, 8'h88);
        irq_is(1'b0);
        wr(`PWC_OFF_SC, 32'h18);
        rd(`PWC_OFF_SC, 8'h98);
        irq_is(1'b1);
        wr(`PWC_OFF_SC, 32'h98);
        rd(`PWC_OFF_SC, 8'h18);
        irq_is(1'b0);
        // Prescaler phase survives an unchanged rewrite but not a limit write.
        wr(`PWC_OFF_SC, 32'h09);
        pulse(0, 1);
        wr(`PWC_OFF_SC, 32'h09);
        pulse(0, 1);
        rd(`PWC_OFF_COUNT, 8'h01);
        pulse(0, 1);
        wr(`PWC_OFF_LIMIT, 32'h10);
        pulse(0, 1);
        rd(`PWC_OFF_COUNT, 8'h00);
        pulse(0, 1);
        wr(`PWC_OFF_COUNT, 32'h55);
        rd(`PWC_OFF_COUNT, 8'h01);
        wr(`PWC_OFF_SC, 32'h08);
        wr(`PWC_OFF_LIMIT, 32'h00);
        pulse(0, 3);
        rd(`PWC_OFF_COUNT, 8'h00);
        rd(`PWC_OFF_SC, 8'h88);
        wr(`PWC_OFF_SC, 32'h88);
        rd(`PWC_OFF_SC, 8'h08);
        pulse(0, 1);
        rd(`PWC_OFF_SC, 8'h88);
        // Event status, mask and read-to-clear.
        wr(`PWC_OFF_SC, 32'h88);
        apb(1'b0, `PWC_OFF_EVT, 32'h0);
        wr(`PWC_OFF_MASK, 32'h01);
        irq_is(1'b0);
        pulse(0, 1);
        irq_is(1'b1);
        wr(`PWC_OFF_MASK, 32'h00);
        irq_is(1'b0);
        rd(`PWC_OFF_EVT, 8'h01);
        rd(`PWC_OFF_EVT, 8'h00);
        wr(`PWC_OFF_MASK, 32'h02);
        wr(`PWC_OFF_LIMIT, 32'h05);
        irq_is(1'b1);
        rd(`PWC_OFF_EVT, 8'h02);
        irq_is(1'b0);
        // Debug halt freezes the count, which then resumes.
        pulse(0, 2);
        rd(`PWC_OFF_COUNT, 8'h02);
        DEBUG_HALT <= 1'b1;
        pulse(0, 3);
        rd(`PWC_OFF_COUNT, 8'h02);
        rd(`PWC_OFF_COUNT, 8'h02);
        DEBUG_HALT <= 1'b0;
        pulse(0, 1);
        rd(`PWC_OFF_COUNT, 8'h03);
        apb(1'b0, 12'h014, 32'h0);
        `PWC_EQ(e, 1'b1)
        `PWC_EQ(r, 32'h0)
        apb(1'b1, 12'hFFC, 32'hFF);
        `PWC_EQ(e, 1'b1)
        rd(`PWC_OFF_LIMIT, 8'h05);
        do_reset(3);
        chk_rst();
        complete_run();
    end
endmodule // pwc_periodic_wakeup_counter_tb

bind pwc_periodic_wakeup_counter pwc_chk #(.ADDR_W(ADDR_W)) u_chk (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DEBUG_HALT(DEBUG_HALT), .IRQ(IRQ));
